//--- pkg/flash_seq_map.svh
// Constants of the serial flash instruction sequencer.
// Assumes a 40 MHz system clock; opcode values are plain defaults.
`ifndef FLASH_SEQ_MAP_SVH
`define FLASH_SEQ_MAP_SVH
`define OPC_READ       8'h03
`define OPC_FAST       8'h0b
`define OPC_DUAL       8'h3b
`define OPC_LOCK       8'he8
`define OPC_OTP        8'h4b
`define OPC_PAGE       8'h02
`define OPC_WRITE_ENABLE_CMD       8'h06
`define OPC_LAST_BIT   5'd7
`define ADDR_LAST_BIT  5'd23
`define OTP_LAST_IDX   7'd64
`define LOCK_RST       2'b00
`define LOCK_DOWN_BIT  1
`define LOCK_WR_BIT    0
`define BLANK_BYTE     8'hff
`define SYS_PERIOD_NS  25
`define PROG_TIME_NS   10000
`define PROG_CYCLES    ((`PROG_TIME_NS + `SYS_PERIOD_NS - 1) / `SYS_PERIOD_NS)
`endif

//--- pkg/flash_seq_pkg.sv
// Types of the serial flash instruction sequencer.
// Assumes nothing beyond the map header.
package flash_seq_pkg;
  typedef enum logic [6:0] {
    ST_IDLE  = 7'b0000001,
    ST_OPC   = 7'b0000010,
    ST_ADDR  = 7'b0000100,
    ST_DUMMY = 7'b0001000,
    ST_OUT   = 7'b0010000,
    ST_PGM   = 7'b0100000,
    ST_IGN   = 7'b1000000
  } seq_state_t;
  typedef enum logic [1:0] {
    K_ARR  = 2'h0,
    K_LOCK = 2'h1,
    K_OTP  = 2'h2
  } rd_kind_t;
endpackage

//--- verilog/flash_seq.sv
// Instruction sequencer of a serial NOR flash: reads, lock read, OTP read, page program.
// Assumes SPI mode 0/3 with the serial clock well below a quarter of i_sys_clk.
// Contract
// - Normal read: opcode then three address bytes sampled on clock rise.
// - Normal read returns memory data on single line, one bit per fall.
// - Array read address increments after each byte and wraps to zero.
// - Chip select high ends a read; device stops driving data.
// - Reads issued while a cycle is busy are rejected, cycle unaffected.
// - Fast read has one dummy byte after the address.
// - Dual read drives both data lines on falls after dummy byte.
// - Array reads and programming ignore the top two address bits.
// - Lock read returns the addressed sector's lock byte on falls.
// - Set lock-down bit freezes that sector's lock bits until power-up.
// - Set write-lock bit blocks program in that sector.
// - OTP read: opcode, address, dummy byte, then incrementing bytes.
// - OTP read uses only low address bits to pick the byte.
// - OTP read stops at the sixty-fifth byte and repeats it.
// - Page program accepted only with write-enable latch set.
// - Programming only clears bits, never sets them.
// - Data past page end wraps to the start of the same page.
// - Over 256 bytes keeps the last 256; untouched bytes stay intact.
// - Select must rise on a byte boundary or program is discarded.
// - Valid program starts timed cycle, busy shown, write-enable cleared.
// - Program into a block-protected page is not executed.
`timescale 1ns/10ps
`include "flash_seq_map.svh"
module flash_seq #(
  parameter int MEM_AW   = 22,
  parameter int PROG_CYC = `PROG_CYCLES
) (
  input  wire logic                i_sys_clk,
  input  wire logic                i_resetn,
  input  wire logic                i_spi_clk,
  input  wire logic                i_spi_csn,
  input  wire logic                i_data_line_in,
  output logic                     o_data_line_in_o,
  output logic                     o_data_line_in_oe,
  output logic                     o_data_line_out,
  output logic                     o_data_line_out_oe,
  input  wire logic [2:0]          i_block_protect,
  input  wire logic                i_lock_wr,
  input  wire logic [MEM_AW-17:0]  i_lock_sector,
  input  wire logic [1:0]          i_lock_bits,
  output logic                     o_write_in_progress,
  output logic                     o_write_enable_latch
);
  import flash_seq_pkg::*;

  localparam int SEC_W = MEM_AW - 16;
  localparam int NSEC  = 1 << SEC_W;

  // ****************************************
  // Storage
  // ****************************************
  logic [7:0] mem  [0:(1<<MEM_AW)-1];
  logic [7:0] otp  [0:64];
  logic [7:0] pbuf [0:255];
  logic [1:0] lock_reg [0:NSEC-1];

  // Erase is handled elsewhere, so the memory and OTP arrays start blank
  initial begin
    for (int i = 0; i < (1 << MEM_AW); i++) begin
      mem[i] = `BLANK_BYTE;
    end
    for (int i = 0; i < 65; i++) begin
      otp[i] = `BLANK_BYTE;
    end
  end

  // ****************************************
  // Pin synchronisers and edge detection
  // ****************************************
  logic [2:0] clk_q;
  logic [2:0] cs_q;
  logic [1:0] din_q;

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      clk_q <= 3'h0;
      cs_q  <= 3'h7;
      din_q <= 2'h0;
    end else begin
      clk_q <= {clk_q[1:0], i_spi_clk};
      cs_q  <= {cs_q[1:0], i_spi_csn};
      din_q <= {din_q[0], i_data_line_in};
    end
  end

  logic rise, fall, sel, cs_fall, cs_rise, din;
  assign rise    = clk_q[1] & ~clk_q[2];
  assign fall    = ~clk_q[1] & clk_q[2];
  assign sel     = ~cs_q[1];
  assign cs_fall = ~cs_q[1] & cs_q[2];
  assign cs_rise = cs_q[1] & ~cs_q[2];
  assign din     = din_q[1];

  // ****************************************
  // Instruction sequencer
  // ****************************************
  seq_state_t state_reg;
  rd_kind_t   kind_reg;
  logic       dual_reg, dummy_reg, busy_reg, wel_reg, pp_any, prot;
  logic [7:0]  sh_in, opc_reg, rd_byte, obyte, col;
  logic [4:0]  bcnt;
  logic [2:0]  ocnt, pbit;
  logic [23:0] addr_reg;
  logic        ostart;
  logic [7:0]  byte_now;
  logic [SEC_W-1:0] sector;
  assign byte_now = {sh_in[6:0], din};
  assign sector   = addr_reg[MEM_AW-1:16];

  function automatic logic is_read(input logic [7:0] op);
    return op == `OPC_READ || op == `OPC_FAST || op == `OPC_DUAL ||
           op == `OPC_LOCK || op == `OPC_OTP;
  endfunction

  logic ld_byte;
  assign ld_byte = fall && sel && state_reg == ST_OUT && ocnt == 3'h0;

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sh_in <= 8'h00;
    end else if (rise && sel) begin
      sh_in <= byte_now;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg <= ST_IDLE;
      bcnt      <= 5'h00;
      opc_reg   <= 8'h00;
      kind_reg  <= K_ARR;
      dual_reg  <= 1'b0;
      dummy_reg <= 1'b0;
      addr_reg  <= 24'h000000;
    end else if (!sel) begin
      state_reg <= ST_IDLE;
    end else if (cs_fall) begin
      state_reg <= ST_OPC;
      bcnt      <= 5'h00;
    end else if (rise) begin
      case (state_reg)
        ST_OPC: begin
          bcnt <= bcnt + 5'h01;
          if (bcnt == `OPC_LAST_BIT) begin
            bcnt      <= 5'h00;
            opc_reg   <= byte_now;
            dual_reg  <= byte_now == `OPC_DUAL;
            dummy_reg <= byte_now == `OPC_FAST || byte_now == `OPC_DUAL ||
                         byte_now == `OPC_OTP;
            kind_reg  <= byte_now == `OPC_LOCK ? K_LOCK :
                         byte_now == `OPC_OTP  ? K_OTP : K_ARR;
            if (is_read(byte_now)) begin
              state_reg <= busy_reg ? ST_IGN : ST_ADDR;
            end else if (byte_now == `OPC_PAGE) begin
              state_reg <= (wel_reg && !busy_reg) ? ST_ADDR : ST_IGN;
            end else begin
              state_reg <= ST_IGN;
            end
          end
        end
        ST_ADDR: begin
          addr_reg <= {addr_reg[22:0], din};
          bcnt     <= bcnt + 5'h01;
          if (bcnt == `ADDR_LAST_BIT) begin
            bcnt      <= 5'h00;
            state_reg <= opc_reg == `OPC_PAGE ? ST_PGM :
                         dummy_reg ? ST_DUMMY : ST_OUT;
          end
        end
        ST_DUMMY: begin
          bcnt <= bcnt + 5'h01;
          if (bcnt == `OPC_LAST_BIT) begin
            state_reg <= ST_OUT;
          end
        end
        ST_IGN: bcnt <= 5'h01;
        default: state_reg <= state_reg;
      endcase
    end else if (ld_byte) begin
      case (kind_reg)
        K_ARR: addr_reg <= addr_reg + 24'h000001;
        K_OTP: if (addr_reg[6:0] < `OTP_LAST_IDX) begin
          addr_reg[6:0] <= addr_reg[6:0] + 7'h01;
        end
        default: addr_reg <= addr_reg;
      endcase
    end
  end

  // ****************************************
  // Read data path
  // ****************************************
  always_comb begin
    case (kind_reg)
      K_ARR:  rd_byte = mem[addr_reg[MEM_AW-1:0]];
      K_LOCK: rd_byte = {6'h00, lock_reg[sector]};
      K_OTP:  rd_byte = addr_reg[6:0] > `OTP_LAST_IDX ? otp[64] :
                        otp[addr_reg[6:0]];
      default: rd_byte = `BLANK_BYTE;
    endcase
  end

  // Output changes on falls so the host can sample on the next rise
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ocnt             <= 3'h0;
      ostart           <= 1'b0;
      obyte            <= 8'h00;
      o_data_line_out  <= 1'b0;
      o_data_line_in_o <= 1'b0;
    end else if (!sel || state_reg != ST_OUT) begin
      ocnt   <= 3'h0;
      ostart <= 1'b0;
    end else if (fall) begin
      ostart <= 1'b1;
      ocnt   <= (dual_reg && ocnt == 3'h3) ? 3'h0 : ocnt + 3'h1;
      if (ocnt == 3'h0) begin
        o_data_line_out  <= rd_byte[7];
        o_data_line_in_o <= rd_byte[6];
        obyte <= dual_reg ? {rd_byte[5:0], 2'b00} : {rd_byte[6:0], 1'b0};
      end else begin
        o_data_line_out  <= obyte[7];
        o_data_line_in_o <= obyte[6];
        obyte <= dual_reg ? {obyte[5:0], 2'b00} : {obyte[6:0], 1'b0};
      end
    end
  end

  assign o_data_line_out_oe = sel && ostart && state_reg == ST_OUT;
  assign o_data_line_in_oe  = o_data_line_out_oe && dual_reg;

  // ****************************************
  // Page program capture
  // ****************************************
  logic [255:0] pmask;
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      col    <= 8'h00;
      pbit   <= 3'h0;
      pmask  <= '0;
      pp_any <= 1'b0;
    end else if (rise && sel && state_reg == ST_ADDR && bcnt == `ADDR_LAST_BIT) begin
      col    <= {addr_reg[6:0], din};
      pbit   <= 3'h0;
      pmask  <= '0;
      pp_any <= 1'b0;
    end else if (rise && sel && state_reg == ST_PGM) begin
      pbit <= pbit + 3'h1;
      if (pbit == 3'h7) begin
        pbuf[col]  <= byte_now;
        pmask[col] <= 1'b1;
        col        <= col + 8'h01;
        pp_any     <= 1'b1;
      end
    end
  end

  // ****************************************
  // Program cycle and write enable
  // ****************************************
  function automatic logic bp_prot(input logic [2:0] bp, input logic [SEC_W-1:0] s);
    if (bp == 3'h0) begin
      return 1'b0;
    end
    if (bp == 3'h7) begin
      return 1'b1;
    end
    return int'(s) >= NSEC - (1 << (int'(bp) - 1));
  endfunction

  logic pp_ok, write_enable_cmd_ok, start;
  logic [15:0] timer;
  logic [MEM_AW-9:0] page_reg;
  assign pp_ok   = cs_rise && state_reg == ST_PGM && pbit == 3'h0 && pp_any;
  assign write_enable_cmd_ok = cs_rise && state_reg == ST_IGN && bcnt == 5'h00 &&
                   opc_reg == `OPC_WRITE_ENABLE_CMD && !busy_reg;
  assign prot    = bp_prot(i_block_protect, sector) ||
                   lock_reg[sector][`LOCK_WR_BIT];
  assign start   = pp_ok && !prot;

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      busy_reg <= 1'b0;
      timer    <= 16'h0000;
      page_reg <= '0;
    end else if (start) begin
      busy_reg <= 1'b1;
      timer    <= 16'h0000;
      page_reg <= addr_reg[MEM_AW-1:8];
    end else if (busy_reg) begin
      timer <= timer + 16'h0001;
      if (timer == 16'(PROG_CYC - 1)) begin
        busy_reg <= 1'b0;
      end
    end
  end

  // One page byte per clock; needs PROG_CYC of at least 256
  always_ff @(posedge i_sys_clk) begin
    if (busy_reg && timer < 16'h0100 && pmask[timer[7:0]]) begin
      mem[{page_reg, timer[7:0]}] <= mem[{page_reg, timer[7:0]}] & pbuf[timer[7:0]];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wel_reg <= 1'b0;
    end else if (start) begin
      wel_reg <= 1'b0;
    end else if (write_enable_cmd_ok) begin
      wel_reg <= 1'b1;
    end
  end

  assign o_write_in_progress  = busy_reg;
  assign o_write_enable_latch = wel_reg;

  // ****************************************
  // Sector lock bits
  // ****************************************
  for (genvar g = 0; g < NSEC; g++) begin : g_lock
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
        lock_reg[g] <= `LOCK_RST;
      end else if (i_lock_wr && i_lock_sector == SEC_W'(g) &&
                   !lock_reg[g][`LOCK_DOWN_BIT]) begin
        lock_reg[g] <= i_lock_bits;
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);

  logic [1:0] lock_sel;
  logic       rd_hi, rd_lo;
  assign lock_sel = lock_reg[i_lock_sector];
  assign rd_hi    = rd_byte[7];
  assign rd_lo    = rd_byte[6];

  sequence s_start;
    start;
  endsequence
  sequence s_busy8;
    busy_reg [*8];
  endsequence

  property p_rd_idle;
    $rose(state_reg == ST_OUT) |-> !busy_reg;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read ran while busy");
  property p_cs_stop;
    !sel |=> !o_data_line_out_oe && !o_data_line_in_oe;
  endproperty
  a_cs_stop: assert property (p_cs_stop) else $error("data driven after select");
  property p_wip;
    s_start |=> s_busy8;
  endproperty
  a_wip: assert property (p_wip) else $error("busy not held");
  property p_wel_clr;
    s_start |=> !wel_reg;
  endproperty
  a_wel_clr: assert property (p_wel_clr) else $error("latch not cleared");
  property p_pp_wel;
    $rose(state_reg == ST_PGM) |-> wel_reg;
  endproperty
  a_pp_wel: assert property (p_pp_wel) else $error("program without latch");
  property p_prot;
    pp_ok && prot |=> !busy_reg;
  endproperty
  a_prot: assert property (p_prot) else $error("protected page programmed");
  property p_otp_sat;
    ld_byte && kind_reg == K_OTP && addr_reg[6:0] == `OTP_LAST_IDX |=>
      addr_reg[6:0] == `OTP_LAST_IDX;
  endproperty
  a_otp_sat: assert property (p_otp_sat) else $error("otp index moved");
  property p_wrap;
    ld_byte && kind_reg == K_ARR |=> addr_reg == $past(addr_reg) + 24'h000001;
  endproperty
  a_wrap: assert property (p_wrap) else $error("address not advanced");
  property p_lockdown;
    i_lock_wr && lock_sel[1] |=> lock_sel == $past(lock_sel) || $changed(i_lock_sector);
  endproperty
  a_lockdown: assert property (p_lockdown) else $error("locked bits changed");
  property p_dual;
    ld_byte && dual_reg |=> o_data_line_out == $past(rd_hi) &&
      o_data_line_in_o == $past(rd_lo);
  endproperty
  a_dual: assert property (p_dual) else $error("dual bit order wrong");
endmodule

//--- tb/spi_host_model.sv
// Host side model: drives select, serial clock and the input data line.
// Assumes a free-running system clock; one serial clock period is 8 system clocks.
`timescale 1ns/10ps
module spi_host_model (
  input  wire logic i_clk,
  input  wire logic i_dq0,
  input  wire logic i_dq1,
  output logic      o_sck,
  output logic      o_csn,
  output logic      o_mosi,
  output logic      o_mosi_oe
);
  initial begin
    o_sck = 1'b0;
    o_csn = 1'b1;
    o_mosi = 1'b0;
    o_mosi_oe = 1'b0;
  end
  task automatic half();
    repeat (4) @(posedge i_clk);
    #1;
  endtask
  task automatic sel();
    @(posedge i_clk);
    #1;
    o_csn = 1'b0;
    o_mosi_oe = 1'b1;
    half();
  endtask
  // Select rises only after whole bits, so the caller decides the byte boundary
  task automatic desel();
    half();
    o_csn = 1'b1;
    o_mosi_oe = 1'b0;
    half();
    half();
  endtask
  task automatic send(input logic [23:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      o_mosi = v[i];
      half();
      o_sck = 1'b1;
      half();
      o_sck = 1'b0;
    end
  endtask
  // Sample just before the fall, where the device output has long settled
  task automatic recv(input logic dual, output logic [7:0] b);
    o_mosi_oe = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      half();
      o_sck = 1'b1;
      half();
      b[i] = i_dq1;
      if (dual) begin
        i--;
        b[i] = i_dq0;
      end
      o_sck = 1'b0;
    end
  endtask
endmodule

//--- tb/flash_seq_tb.sv
// Self-checking bench of the flash instruction sequencer.
// Assumes the host model in spi_host_model.sv; small memory, program time of 600 cycles.
`timescale 1ns/10ps
`include "flash_seq_map.svh"
module flash_seq_tb;
  localparam int AW = 17;
  localparam int PC = 600;
  logic             sys_clk = 1'b0;
  logic             resetn, sck, csn, mosi, mosi_oe, dq0, dq1;
  logic             d0_o, d0_oe, d1_o, d1_oe, write_in_progress, write_enable_latch, lock_wr, seen_oe;
  logic [2:0]       bp;
  logic [AW-17:0]   lock_sector;
  logic [1:0]       lock_bits;
  logic [7:0]       q[$];
  int               fails = 0;
  int               check_count = 0;
  int               cycles = 0;
  // ****************
  // Wiring
  // ****************
  // No pull-ups: a released line shows the inverse of its last value
  assign dq0 = d0_oe ? d0_o : (mosi_oe ? mosi : ~mosi);
  assign dq1 = d1_oe ? d1_o : ~d1_o;
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (d1_oe) seen_oe <= 1'b1;
    cycles++;
    if (cycles == 60000) begin
      fails++;
      test_done();
    end
  end
  flash_seq #(.MEM_AW(AW), .PROG_CYC(PC)) i_flash_seq (
    .i_sys_clk(sys_clk), .i_resetn(resetn), .i_spi_clk(sck), .i_spi_csn(csn),
    .i_data_line_in(dq0), .o_data_line_in_o(d0_o), .o_data_line_in_oe(d0_oe),
    .o_data_line_out(d1_o), .o_data_line_out_oe(d1_oe), .i_block_protect(bp),
    .i_lock_wr(lock_wr), .i_lock_sector(lock_sector), .i_lock_bits(lock_bits),
    .o_write_in_progress(write_in_progress), .o_write_enable_latch(write_enable_latch));
  spi_host_model i_spi_host_model (
    .i_clk(sys_clk), .i_dq0(dq0), .i_dq1(dq1), .o_sck(sck), .o_csn(csn),
    .o_mosi(mosi), .o_mosi_oe(mosi_oe));
  // ****************
  // Shared tasks
  // ****************
  task automatic check(input string w, input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", w, exp, got);
    end
  endtask
  task automatic test_done();
    $display("Checks %0d errors %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmd(input logic [7:0] op, input logic [23:0] a);
    i_spi_host_model.sel();
    i_spi_host_model.send({16'h0000, op}, 8);
    i_spi_host_model.send(a, 24);
    if (op == `OPC_FAST || op == `OPC_DUAL || op == `OPC_OTP)
      i_spi_host_model.send(24'h000000, 8);
  endtask
  task automatic rd_chk(input string w, input logic [7:0] op, input logic [23:0] a,
                        input logic [7:0] e0, input logic [7:0] e1);
    logic [7:0] b;
    cmd(op, a);
    i_spi_host_model.recv(op == `OPC_DUAL, b);
    check(w, b, e0);
    i_spi_host_model.recv(op == `OPC_DUAL, b);
    check(w, b, e1);
    i_spi_host_model.desel();
    check("dq1 released", {7'h00, d1_oe}, 8'h00);
    check("dq0 released", {7'h00, d0_oe}, 8'h00);
  endtask
  task automatic write_enable_cmd();
    i_spi_host_model.sel();
    i_spi_host_model.send({16'h0000, `OPC_WRITE_ENABLE_CMD}, 8);
    i_spi_host_model.desel();
  endtask
  task automatic prog(input logic [23:0] a, input int extra);
    cmd(`OPC_PAGE, a);
    foreach (q[i]) i_spi_host_model.send({16'h0000, q[i]}, 8);
    if (extra > 0) i_spi_host_model.send(24'h000000, extra);
    i_spi_host_model.desel();
  endtask
  task automatic wait_idle();
    for (int n = 0; n < PC + 100 && write_in_progress !== 1'b0; n++) @(posedge sys_clk);
    check("program done", {7'h00, write_in_progress}, 8'h00);
    #1;
  endtask
  task automatic lock_set(input logic s, input logic [1:0] v);
    @(posedge sys_clk);
    #1;
    lock_sector = s;
    lock_bits = v;
    lock_wr = 1'b1;
    @(posedge sys_clk);
    #1;
    lock_wr = 1'b0;
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic s_prog_wrap();
    logic [7:0] b;
    write_enable_cmd();
    check("wel set", {7'h00, write_enable_latch}, 8'h01);
    q = {8'ha5, 8'h3c, 8'h0f};
    prog(24'hc000fe, 0);
    check("wip set", {7'h00, write_in_progress}, 8'h01);
    check("wel cleared", {7'h00, write_enable_latch}, 8'h00);
    seen_oe = 1'b0;
    cmd(`OPC_READ, 24'h0000fe);
    i_spi_host_model.recv(1'b0, b);
    i_spi_host_model.desel();
    check("busy read", {7'h00, seen_oe}, 8'h00);
    check("busy kept", {7'h00, write_in_progress}, 8'h01);
    wait_idle();
    rd_chk("read wrap", `OPC_READ, 24'hc1ffff, 8'hff, 8'h0f);
    rd_chk("fast read", `OPC_FAST, 24'h0000fe, 8'ha5, 8'h3c);
    rd_chk("dual read", `OPC_DUAL, 24'h0000ff, 8'h3c, 8'hff);
  endtask
  task automatic s_and();
    write_enable_cmd();
    q = {8'h5a};
    prog(24'h0000fe, 0);
    wait_idle();
    rd_chk("and prog", `OPC_READ, 24'h0000fe, 8'h00, 8'h3c);
  endtask
  task automatic s_refuse();
    q = {8'h00};
    prog(24'h000010, 0);
    check("no wel", {7'h00, write_in_progress}, 8'h00);
    write_enable_cmd();
    prog(24'h000010, 3);
    check("off boundary", {7'h00, write_in_progress}, 8'h00);
    check("wel kept", {7'h00, write_enable_latch}, 8'h01);
    bp = 3'h7;
    prog(24'h000010, 0);
    check("protected", {7'h00, write_in_progress}, 8'h00);
    bp = 3'h0;
    rd_chk("refused", `OPC_READ, 24'h000010, 8'hff, 8'hff);
  endtask
  task automatic s_lock();
    rd_chk("lock rst", `OPC_LOCK, 24'h000123, 8'h00, 8'h00);
    lock_set(1'b1, 2'b01);
    rd_chk("lock byte", `OPC_LOCK, 24'h01abcd, 8'h01, 8'h01);
    q = {8'h00};
    prog(24'h010000, 0);
    check("locked prog", {7'h00, write_in_progress}, 8'h00);
    lock_set(1'b1, 2'b11);
    lock_set(1'b1, 2'b00);
    rd_chk("lock down", `OPC_LOCK, 24'h010000, 8'h03, 8'h03);
    rd_chk("locked data", `OPC_READ, 24'h010000, 8'hff, 8'hff);
  endtask
  task automatic s_otp();
    rd_chk("otp end", `OPC_OTP, 24'hffff3f, 8'hff, 8'hff);
  endtask
  task automatic s_big();
    write_enable_cmd();
    q.delete();
    for (int i = 0; i <= 256; i++) q.push_back(i == 0 ? 8'h00 : (i == 256 ? 8'h3c : 8'hff));
    prog(24'h000200, 0);
    wait_idle();
    rd_chk("last 256", `OPC_READ, 24'h000200, 8'h3c, 8'hff);
  endtask
  initial begin
    resetn = 1'b0;
    bp = 3'h0;
    lock_wr = 1'b0;
    lock_sector = '0;
    lock_bits = 2'b00;
    seen_oe = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    resetn = 1'b1;
    repeat (3) @(posedge sys_clk);
    s_prog_wrap();
    s_and();
    s_refuse();
    s_lock();
    s_otp();
    s_big();
    test_done();
  end
endmodule
